// [bench/fsp_ctrl_bench.sv]
// Self-checking bench for the flash self-program controller
module fsp_ctrl_bench
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk, nrst, sfr_wr, sfr_rd, sfr_hit, loader_present, exec_in_loader;
  logic           cpu_stall, soft_reset, boot_from_loader, vendor_loader_req;
  logic [7:0]     sfr_addr, sfr_wdata, sfr_rdata;
  logic [15:0]    loader_start, data_region_size, data_lo, data_hi;
  logic [3:0]     lat;
  fsp_flash_req_t flash_req;
  fsp_flash_rsp_t flash_rsp;
  int             err_total, n_checks, cycles;

  fsp_ctrl fsp_ctrl_inst (.clk(clk), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .loader_present(loader_present), .loader_start(loader_start),
    .data_region_size(data_region_size), .exec_in_loader(exec_in_loader),
    .cpu_stall(cpu_stall), .soft_reset(soft_reset), .boot_from_loader(boot_from_loader),
    .vendor_loader_req(vendor_loader_req), .flash_req(flash_req), .flash_rsp(flash_rsp),
    .data_lo(data_lo), .data_hi(data_hi));
  fsp_flash_model fsp_flash_model_inst (.clk(clk), .lat(lat), .req(flash_req),
    .rsp(flash_rsp));

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {2'b10, a, d};
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    {sfr_rd, sfr_addr} = {1'b1, a};
    #2 chk(what, {8'h00, exp}, {8'h00, sfr_rdata});
  endtask

  // Load mode, address and data, then send the unlock pair
  task op(input logic [7:0] ctrl, input logic [15:0] a, input logic [7:0] d, input logic go);
    wr(FSP_ADDR_CONTROL, ctrl);
    wr(FSP_ADDR_ADR_HIGH, a[15:8]);
    wr(FSP_ADDR_ADR_LOW, a[7:0]);
    wr(FSP_ADDR_DATA, d);
    wr(FSP_ADDR_UNLOCK, FSP_UNLOCK_FIRST);
    wr(FSP_ADDR_UNLOCK, FSP_UNLOCK_SECOND);
    chk("launch", {15'h0, go}, {15'h0, flash_req.req});
    chk("stall", {15'h0, go}, {15'h0, cpu_stall});
    for (int i = 0; i < 60 && cpu_stall !== 1'b0; i++) @(negedge clk);
    chk("stall end", 16'h0000, {15'h0, cpu_stall});
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      conclude;
    end
  end

  initial begin
    {nrst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, exec_in_loader} = '0;
    {lat, loader_present, loader_start, data_region_size} = {4'h2, 1'b1, 16'h3800, 16'h0400};
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    rd("control", FSP_ADDR_CONTROL, 8'h00);
    rd("unmapped", 8'he5, 8'h00);
    chk("data low", 16'h3400, data_lo);
    chk("data high", 16'h37ff, data_hi);
    op(8'h02, 16'h3400, 8'h5a, 1'b0);
    op(8'h82, 16'h3400, 8'h5a, 1'b1);
    rd("fail clear", FSP_ADDR_CONTROL, 8'h82);
    op(8'h81, 16'h3400, 8'h00, 1'b1);
    rd("read byte", FSP_ADDR_DATA, 8'h5a);
    op(8'h83, 16'h3555, 8'h00, 1'b1);
    op(8'h81, 16'h3400, 8'h00, 1'b1);
    rd("erased", FSP_ADDR_DATA, 8'hff);
    op(8'h82, 16'h3400, 8'h77, 1'b1);
    op(8'h81, 16'h3400, 8'h00, 1'b1);
    rd("rewritten", FSP_ADDR_DATA, 8'h77);
    op(8'h82, 16'h1000, 8'h11, 1'b0);
    rd("fail set", FSP_ADDR_CONTROL, 8'h92);
    @(negedge clk);
    {exec_in_loader, lat} = {1'b1, 4'h9};
    op(8'h82, 16'h1000, 8'h11, 1'b1);
    op(8'h81, 16'h1000, 8'h00, 1'b1);
    rd("loader write", FSP_ADDR_DATA, 8'h11);
    op(8'h82, 16'h1000, 8'hee, 1'b1);
    rd("fail on error", FSP_ADDR_CONTROL, 8'h92);
    op(8'h80, 16'h1000, 8'h00, 1'b0);
    wr(FSP_ADDR_CONTROL, 8'h81);
    wr(FSP_ADDR_UNLOCK, FSP_UNLOCK_FIRST);
    wr(FSP_ADDR_UNLOCK, 8'h55);
    wr(FSP_ADDR_UNLOCK, FSP_UNLOCK_SECOND);
    chk("broken pair", 16'h0000, {15'h0, flash_req.req});
    chk("broken stall", 16'h0000, {15'h0, cpu_stall});
    wr(FSP_ADDR_CONTROL, 8'h68);
    chk("soft reset", 16'h0001, {15'h0, soft_reset});
    chk("boot select", 16'h0001, {15'h0, boot_from_loader});
    chk("loader flag", 16'h0001, {15'h0, vendor_loader_req});
    rd("control bits", FSP_ADDR_CONTROL, 8'h58);
    chk("reset pulse end", 16'h0000, {15'h0, soft_reset});
    loader_present = 1'b0;
    #2 chk("top low", 16'h3c00, data_lo);
    chk("top high", 16'h3fff, data_hi);
    conclude;
  end
endmodule

// [bench/fsp_flash_model.sv]
// Behavioural flash array facing the self-program controller
module fsp_flash_model
  import fsp_pkg::*;
(
  // Clock
  input  wire logic           clk,
  // Answer delay in cycles
  input  wire logic [3:0]     lat,
  // Controller side
  input  wire fsp_flash_req_t req,
  output fsp_flash_rsp_t      rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]     mem [0:16383];
  fsp_flash_req_t cur;
  logic [3:0]     cnt;
  logic           busy;

  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    busy = 1'b0;
    rsp  = '0;
  end

  // Read data toggles outside the answer cycle so a stale byte is never mistaken
  always @(posedge clk) begin
    rsp.done  <= 1'b0;
    rsp.error <= 1'b0;
    rsp.rdata <= ~rsp.rdata;
    if (req.req) begin
      cur  <= req;
      cnt  <= lat;
      busy <= 1'b1;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy     <= 1'b0;
      rsp.done <= 1'b1;
      case (cur.mode)
        FSP_MODE_READ: rsp.rdata <= mem[cur.addr[13:0]];
        // Real cells only clear bits when programmed
        FSP_MODE_PROGRAM: begin
          // Raising a cleared bit cannot work, so report it as a failure
          rsp.error <= (mem[cur.addr[13:0]] & cur.wdata) != cur.wdata;
          mem[cur.addr[13:0]] = mem[cur.addr[13:0]] & cur.wdata;
        end
        FSP_MODE_ERASE: for (int i = 0; i < 512; i++) begin
          mem[{cur.addr[13:9], 9'h000} + i] = 8'hff;
        end
        default: ;
      endcase
    end
  end
endmodule

// [logic/fsp_ctrl.sv]
// Flash self-program controller: registers, unlock, stall and region guard
// Behaviour
// R1: 16K flash holds application, data and loader regions in one byte space.
// R2: No command starts unless the enable bit 7 is set.
// R3: Bit 6 selects loader boot after soft reset, else application boot.
// R4: Writing one to bit 5 triggers a software reset.
// R5: Fail flag bit 4 cleared on success, set on error of last command.
// R6: Software sets boot select and loader flag for vendor loader, else zero.
// R7: Mode field 00 idle, 01 read, 10 program, 11 page erase.
// R8: Page erase clears a whole 512-byte page; no byte erase.
// R9: High and low address registers form the byte address for all modes.
// R10: Data register supplies program byte and receives read byte.
// R11: Operation starts only on 0x46 then 0xb9 with enable set.
// R12: The processor stalls until the triggered command finishes.
// R13: After a read the flash byte sits in the data register.
// R14: Software sets divider, mode, address, data, then the trigger pair; there is no divider register here, control carries enable and mode.
// R15: With loader, data region ends below loader start, size given.
// R16: Without loader, data region ends 0x3fff, begins 0x4000 minus size.
// R17: Loader code may program application and data regions.
// R18: Application code may program only the data region, never the loader.
// R19: Byte change goes by page copy, erase, modify and reprogram.
// R20: Data region readable by code fetch reads and by read mode.
// R21: A wrong second unlock byte discards the sequence, starts nothing.
// R22: Out-of-bounds command changes nothing and sets the fail flag.
module fsp_ctrl
  import fsp_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // Special function register port
  input  wire logic           sfr_wr,
  input  wire logic           sfr_rd,
  input  wire logic [7:0]     sfr_addr,
  input  wire logic [7:0]     sfr_wdata,
  output logic      [7:0]     sfr_rdata,
  output logic                sfr_hit,
  // Partition configuration
  input  wire logic           loader_present,
  input  wire logic [15:0]    loader_start,
  input  wire logic [15:0]    data_region_size,
  input  wire logic           exec_in_loader,
  // Processor control
  output logic                cpu_stall,
  output logic                soft_reset,
  output logic                boot_from_loader,
  output logic                vendor_loader_req,
  // Flash array
  output fsp_flash_req_t      flash_req,
  input  wire fsp_flash_rsp_t flash_rsp,
  // Region bounds
  output logic      [15:0]    data_lo,
  output logic      [15:0]    data_hi
);
  logic [7:0]     ctrl_reg, ctrl_next;
  logic [7:0]     data_reg, data_next;
  logic [7:0]     adr_hi_reg;
  logic [7:0]     adr_lo_reg;
  logic           rst_reg;
  fsp_state_t     state_reg, state_next;
  fsp_flash_req_t req_reg, req_next;

  wire            wr_ctrl    = sfr_wr && sfr_addr == FSP_ADDR_CONTROL;
  wire            wr_data    = sfr_wr && sfr_addr == FSP_ADDR_DATA;
  wire            wr_unlock  = sfr_wr && sfr_addr == FSP_ADDR_UNLOCK;
  wire            enabled    = ctrl_reg[FSP_BIT_ENABLE];
  wire fsp_mode_t mode       = fsp_mode_t'(ctrl_reg[1:0]);
  wire [15:0]     byte_addr  = {adr_hi_reg, adr_lo_reg}; // R9
  wire [15:0]     op_addr    = (mode == FSP_MODE_ERASE) ? (byte_addr & FSP_PAGE_MASK)
                                                        : byte_addr; // R8
  wire [15:0]     region_end = loader_present ? loader_start : FSP_FLASH_SIZE;
  // R15 R16
  assign data_hi = region_end - 16'h0001;
  assign data_lo = region_end - data_region_size;

  // Loader code may touch everything below itself; application only data
  wire            in_flash   = op_addr <= FSP_FLASH_TOP; // R1
  wire            in_data    = op_addr >= data_lo && op_addr <= data_hi;
  wire            below_ldr  = op_addr < region_end;
  wire            modify_ok  = exec_in_loader ? below_ldr : in_data; // R17 R18
  wire            addr_ok    = (mode == FSP_MODE_READ) ? in_flash : modify_ok; // R20 R22
  wire            trigger    = wr_unlock && sfr_wdata == FSP_UNLOCK_SECOND
                               && state_reg == FSP_ST_ARMED && enabled; // R2 R11
  wire            launch     = trigger && mode != FSP_MODE_IDLE && addr_ok; // R7
  wire            reject     = trigger && mode != FSP_MODE_IDLE && !addr_ok; // R22

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FSP_ST_IDLE: begin
        if (wr_unlock && sfr_wdata == FSP_UNLOCK_FIRST && enabled) begin
          state_next = FSP_ST_ARMED;
        end
      end
      FSP_ST_ARMED: begin
        if (launch) begin
          state_next = FSP_ST_BUSY; // R11
        end else if (wr_unlock && sfr_wdata == FSP_UNLOCK_FIRST && enabled) begin
          state_next = FSP_ST_ARMED;
        end else if (sfr_wr || !enabled) begin
          state_next = FSP_ST_IDLE; // R21
        end
      end
      FSP_ST_BUSY: begin
        if (flash_rsp.done) begin
          state_next = FSP_ST_IDLE;
        end
      end
      default: state_next = FSP_ST_IDLE;
    endcase
  end

  always_comb begin
    req_next = req_reg;
    req_next.req = 1'b0;
    if (launch) begin
      req_next.req   = 1'b1;
      req_next.mode  = mode;
      req_next.addr  = op_addr;
      req_next.wdata = data_reg; // R10
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = {sfr_wdata[7:6], 1'b0, ctrl_reg[FSP_BIT_FAIL], sfr_wdata[3], 1'b0,
                   sfr_wdata[1:0]};
    end
    // Hardware outcome wins over a software write in the same cycle
    if (state_reg == FSP_ST_BUSY && flash_rsp.done) begin
      ctrl_next[FSP_BIT_FAIL] = flash_rsp.error; // R5
    end else if (reject) begin
      ctrl_next[FSP_BIT_FAIL] = 1'b1; // R22
    end
  end

  always_comb begin
    data_next = data_reg;
    if (wr_data) begin
      data_next = sfr_wdata;
    end
    if (state_reg == FSP_ST_BUSY && flash_rsp.done && req_reg.mode == FSP_MODE_READ
        && !flash_rsp.error) begin
      data_next = flash_rsp.rdata; // R13
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= FSP_ST_IDLE;
      ctrl_reg   <= FSP_CTRL_RESET;
      data_reg   <= FSP_BYTE_RESET;
      adr_hi_reg <= FSP_BYTE_RESET;
      adr_lo_reg <= FSP_BYTE_RESET;
      req_reg    <= '0;
      rst_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      data_reg   <= data_next;
      req_reg    <= req_next;
      rst_reg    <= wr_ctrl && sfr_wdata[FSP_BIT_SOFT_RST]; // R4
      if (sfr_wr && sfr_addr == FSP_ADDR_ADR_HIGH) begin
        adr_hi_reg <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == FSP_ADDR_ADR_LOW) begin
        adr_lo_reg <= sfr_wdata;
      end
    end
  end

  assign flash_req         = req_reg;
  assign soft_reset        = rst_reg;
  assign boot_from_loader  = ctrl_reg[FSP_BIT_BOOT_SEL]; // R3
  assign vendor_loader_req = ctrl_reg[FSP_BIT_LOADER]; // R6
  // Stall from the trigger write itself so no instruction slips past
  assign cpu_stall         = launch || state_reg == FSP_ST_BUSY; // R12

  // Unlock port and reset pulse read back as zero
  wire rd_data = sfr_addr == FSP_ADDR_DATA;
  wire rd_hi   = sfr_addr == FSP_ADDR_ADR_HIGH;
  wire rd_lo   = sfr_addr == FSP_ADDR_ADR_LOW;
  wire rd_ctl  = sfr_addr == FSP_ADDR_CONTROL;
  assign sfr_hit   = rd_data || rd_hi || rd_lo || rd_ctl || sfr_addr == FSP_ADDR_UNLOCK;
  assign sfr_rdata = !sfr_rd ? 8'h00 :
                     rd_data ? data_reg :
                     rd_hi   ? adr_hi_reg :
                     rd_lo   ? adr_lo_reg :
                     rd_ctl  ? ctrl_reg : 8'h00;

  sequence unlock_pair_s;
    wr_unlock && sfr_wdata == FSP_UNLOCK_FIRST && enabled && state_reg == FSP_ST_IDLE
      ##1 trigger && mode != FSP_MODE_IDLE && addr_ok;
  endsequence

  unlock_starts_a: assert property (@(posedge clk) disable iff (!nrst) // R11
    unlock_pair_s |=> flash_req.req && state_reg == FSP_ST_BUSY)
    else $error("unlock pair did not start a command");
  enable_gate_a: assert property (@(posedge clk) disable iff (!nrst) // R2
    flash_req.req |-> $past(ctrl_reg[FSP_BIT_ENABLE]))
    else $error("command started while disabled");
  bad_second_a: assert property (@(posedge clk) disable iff (!nrst) // R21
    state_reg == FSP_ST_ARMED && wr_unlock && sfr_wdata != FSP_UNLOCK_SECOND
      && sfr_wdata != FSP_UNLOCK_FIRST |=> state_reg == FSP_ST_IDLE && !flash_req.req)
    else $error("wrong unlock byte not discarded");
  cpu_stall_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    flash_req.req |-> cpu_stall throughout (state_reg == FSP_ST_BUSY)[*1])
    else $error("processor not stalled during command");
  soft_reset_a: assert property (@(posedge clk) disable iff (!nrst) // R4
    wr_ctrl && sfr_wdata[FSP_BIT_SOFT_RST] |=> soft_reset ##1 !soft_reset || wr_ctrl)
    else $error("soft reset pulse wrong");
  fail_flag_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    state_reg == FSP_ST_BUSY && flash_rsp.done |=> ctrl_reg[FSP_BIT_FAIL] == $past(flash_rsp.error))
    else $error("fail flag does not follow outcome");
  reject_flag_a: assert property (@(posedge clk) disable iff (!nrst) // R22
    reject |=> ctrl_reg[FSP_BIT_FAIL] && !flash_req.req && state_reg == FSP_ST_IDLE)
    else $error("out of region command not refused");
  read_data_a: assert property (@(posedge clk) disable iff (!nrst) // R13
    state_reg == FSP_ST_BUSY && flash_rsp.done && req_reg.mode == FSP_MODE_READ
      && !flash_rsp.error |=> data_reg == $past(flash_rsp.rdata))
    else $error("read byte not captured");
  page_align_a: assert property (@(posedge clk) disable iff (!nrst) // R8
    flash_req.req && flash_req.mode == FSP_MODE_ERASE |-> flash_req.addr[8:0] == 9'h000)
    else $error("erase address not page aligned");
  app_bound_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    launch && !exec_in_loader && mode != FSP_MODE_READ |-> op_addr >= data_lo
      && op_addr <= data_hi)
    else $error("application modifies outside data region");

  // Building blocks for the multi-step command checks
  sequence command_done_s;
    state_reg == FSP_ST_BUSY && flash_rsp.done;
  endsequence

  sequence first_byte_s;
    wr_unlock && sfr_wdata == FSP_UNLOCK_FIRST && enabled && state_reg == FSP_ST_IDLE;
  endsequence

  sequence wrong_second_s;
    sfr_wr && !(wr_unlock && sfr_wdata == FSP_UNLOCK_SECOND)
      && !(wr_unlock && sfr_wdata == FSP_UNLOCK_FIRST);
  endsequence

  broken_pair_a: assert property (@(posedge clk) disable iff (!nrst) // R21
    first_byte_s ##1 wrong_second_s |=> state_reg == FSP_ST_IDLE && !flash_req.req)
    else $error("interrupted unlock pair still armed");

  stall_release_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    command_done_s |=> !cpu_stall)
    else $error("processor still stalled after command end");

  done_idle_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    command_done_s |=> state_reg == FSP_ST_IDLE)
    else $error("engine not idle after command end");

  read_keep_a: assert property (@(posedge clk) disable iff (!nrst) // R13
    command_done_s and (req_reg.mode == FSP_MODE_READ && flash_rsp.error && !wr_data)
      |=> $stable(data_reg))
    else $error("failed read disturbed data register");

  stall_busy_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    state_reg == FSP_ST_BUSY |-> cpu_stall)
    else $error("processor runs while command busy");

  boot_select_a: assert property (@(posedge clk) disable iff (!nrst) // R3
    wr_ctrl |=> boot_from_loader == $past(sfr_wdata[FSP_BIT_BOOT_SEL]))
    else $error("boot select does not follow control write");

  loader_flag_a: assert property (@(posedge clk) disable iff (!nrst) // R6
    wr_ctrl |=> vendor_loader_req == $past(sfr_wdata[FSP_BIT_LOADER]))
    else $error("loader flag does not follow control write");

  idle_mode_a: assert property (@(posedge clk) disable iff (!nrst) // R7
    trigger && mode == FSP_MODE_IDLE |=> !flash_req.req && state_reg == FSP_ST_IDLE)
    else $error("idle mode started a command");

  mode_pass_a: assert property (@(posedge clk) disable iff (!nrst) // R7
    flash_req.req |-> flash_req.mode == $past(mode) && flash_req.mode != FSP_MODE_IDLE)
    else $error("command mode differs from control field");

  addr_form_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    flash_req.req && flash_req.mode != FSP_MODE_ERASE |-> flash_req.addr == $past(byte_addr))
    else $error("command address differs from address registers");

  erase_page_a: assert property (@(posedge clk) disable iff (!nrst) // R8
    flash_req.req && flash_req.mode == FSP_MODE_ERASE
      |-> flash_req.addr == $past(byte_addr & FSP_PAGE_MASK))
    else $error("erase page differs from address registers");

  addr_high_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    sfr_wr && sfr_addr == FSP_ADDR_ADR_HIGH |=> adr_hi_reg == $past(sfr_wdata))
    else $error("high address write lost");

  addr_low_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    sfr_wr && sfr_addr == FSP_ADDR_ADR_LOW |=> adr_lo_reg == $past(sfr_wdata))
    else $error("low address write lost");

  prog_byte_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    flash_req.req |-> flash_req.wdata == $past(data_reg))
    else $error("program byte differs from data register");

  data_write_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    wr_data && state_reg != FSP_ST_BUSY |=> data_reg == $past(sfr_wdata))
    else $error("data register write lost");

  flash_range_a: assert property (@(posedge clk) disable iff (!nrst) // R1
    flash_req.req |-> flash_req.addr <= FSP_FLASH_TOP)
    else $error("command address beyond flash");

  loader_span_a: assert property (@(posedge clk) disable iff (!nrst) // R17
    launch && exec_in_loader && mode != FSP_MODE_READ |-> op_addr < region_end)
    else $error("loader code modifies itself");

  loader_guard_a: assert property (@(posedge clk) disable iff (!nrst) // R18
    launch && !exec_in_loader && mode != FSP_MODE_READ && loader_present
      |-> op_addr < loader_start)
    else $error("application code modifies loader region");

  read_anywhere_a: assert property (@(posedge clk) disable iff (!nrst) // R20
    trigger && mode == FSP_MODE_READ && op_addr <= FSP_FLASH_TOP |=> flash_req.req)
    else $error("read inside flash refused");

  disabled_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // R2
    !enabled && state_reg != FSP_ST_BUSY |=> state_reg == FSP_ST_IDLE)
    else $error("engine armed while disabled");

  fail_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    !(state_reg == FSP_ST_BUSY && flash_rsp.done) && !reject |=> $stable(ctrl_reg[FSP_BIT_FAIL]))
    else $error("fail flag changed without a command outcome");

  reset_once_a: assert property (@(posedge clk) disable iff (!nrst) // R4
    soft_reset |-> $past(wr_ctrl && sfr_wdata[FSP_BIT_SOFT_RST]))
    else $error("soft reset without a control write");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst) // R4
    ctrl_reg[FSP_BIT_SOFT_RST] == 1'b0 && ctrl_reg[2] == 1'b0)
    else $error("trigger or reserved control bit held");

  // Software must never see an unlock byte echoed back
  unlock_read_a: assert property (@(posedge clk) disable iff (!nrst) // R11
    sfr_rd && sfr_addr == FSP_ADDR_UNLOCK |-> sfr_rdata == 8'h00)
    else $error("unlock port reads back data");

  idle_read_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    !sfr_rd |-> sfr_rdata == 8'h00)
    else $error("read data driven without read");
endmodule

// [logic/fsp_pkg.sv]
// Package for the flash self-program controller
package fsp_pkg;
  localparam logic [7:0]  FSP_ADDR_DATA     = 8'he2;
  localparam logic [7:0]  FSP_ADDR_ADR_HIGH = 8'he3;
  localparam logic [7:0]  FSP_ADDR_ADR_LOW  = 8'he4;
  localparam logic [7:0]  FSP_ADDR_UNLOCK   = 8'he6;
  localparam logic [7:0]  FSP_ADDR_CONTROL  = 8'he7;
  localparam int          FSP_BIT_ENABLE    = 7;
  localparam int          FSP_BIT_BOOT_SEL  = 6;
  localparam int          FSP_BIT_SOFT_RST  = 5;
  localparam int          FSP_BIT_FAIL      = 4;
  localparam int          FSP_BIT_LOADER    = 3;
  localparam logic [7:0]  FSP_UNLOCK_FIRST  = 8'h46;
  localparam logic [7:0]  FSP_UNLOCK_SECOND = 8'hb9;
  localparam logic [7:0]  FSP_CTRL_RESET    = 8'h00;
  localparam logic [7:0]  FSP_BYTE_RESET    = 8'h00;
  localparam logic [15:0] FSP_FLASH_SIZE    = 16'h4000;
  localparam logic [15:0] FSP_FLASH_TOP     = 16'h3fff;
  localparam int          FSP_PAGE_BITS     = 9;
  localparam logic [15:0] FSP_PAGE_MASK     = 16'hfe00;

  typedef enum logic [1:0] {
    FSP_MODE_IDLE    = 2'h0,
    FSP_MODE_READ    = 2'h1,
    FSP_MODE_PROGRAM = 2'h2,
    FSP_MODE_ERASE   = 2'h3
  } fsp_mode_t;

  typedef enum logic [1:0] {
    FSP_ST_IDLE = 2'h0,
    FSP_ST_ARMED = 2'h1,
    FSP_ST_BUSY = 2'h3
  } fsp_state_t;

  typedef struct packed {
    logic        req;
    fsp_mode_t   mode;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fsp_flash_req_t;

  typedef struct packed {
    logic       done;
    logic       error;
    logic [7:0] rdata;
  } fsp_flash_rsp_t;
endpackage
